// File: rtl/dma_ctrl_params.svh
// constants for the dma channel control register block
`ifndef DMA_CTRL_PARAMS_SVH
`define DMA_CTRL_PARAMS_SVH
`define ADDR_CTRL_STATUS   4'h8
`define ADDR_SOFT_REQ      4'h9
`define ADDR_MASK_ONE      4'hA
`define ADDR_MODE          4'hB
`define ADDR_CLEAR_MASKS   4'hE
`define ADDR_TEMP_RESET    4'hD
`define ADDR_MASK_ALL      4'hF
`define BIT_ACK_LEVEL      7
`define BIT_REQ_LEVEL      6
`define BIT_EXT_WRITE      5
`define BIT_ROTATE         4
`define BIT_COMPRESSED     3
`define BIT_DISABLE        2
`define BIT_SRC_HOLD       1
`define BIT_MEM_TO_MEM     0
`define BIT_SET_FLAG       2
`define CTRL_RESET         8'h00
`define MASK_RESET         4'hF
`define FIFO_DEPTH         8
`endif

// File: rtl/dma_ctrl_pkg.sv
// types shared by the dma channel control register block
package dma_ctrl_pkg;
	typedef enum logic [1:0] {
		MODE_DEMAND = 2'b00,
		MODE_SINGLE = 2'b01,
		MODE_BLOCK  = 2'b10,
		MODE_CASC   = 2'b11
	} xfer_mode_t;
	typedef enum logic [1:0] {
		DIR_VERIFY  = 2'b00,
		DIR_IO_MEM  = 2'b01,
		DIR_MEM_IO  = 2'b10,
		DIR_INHIBIT = 2'b11
	} xfer_dir_t;
	typedef struct packed {
		xfer_mode_t xfer_mode;
		logic       addr_dir;
		logic       auto_reload;
		xfer_dir_t  xfer_dir;
	} chan_mode_t;
	typedef struct packed {
		logic       ack_level_sel;
		logic       req_level_sel;
		logic       extended_write;
		logic       rotate_priority;
		logic       compressed_timing;
		logic       dma_disable;
		logic       src_addr_hold;
		logic       mem_to_mem_en;
	} dev_ctrl_t;
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [3:0] addr;
		logic [7:0] wdata;
	} host_req_t;
endpackage : dma_ctrl_pkg

// File: rtl/byte_fifo.sv
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             ref_clk,
	input  wire logic             reset,
	input  wire logic             clk_en,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wptr_reg;
	logic [AW-1:0]    rptr_reg;
	logic [AW:0]      count_reg;
	logic             push;
	logic             pop;
	assign in_ready  = (count_reg != (AW+1)'(DEPTH));
	assign out_valid = (count_reg != '0);
	assign out_data  = mem_reg[rptr_reg];
	assign push      = clk_en && in_valid && in_ready;
	assign pop       = clk_en && out_valid && out_ready;
	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem_reg[wptr_reg] <= in_data;
		end
	end
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			wptr_reg  <= '0;
			rptr_reg  <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wptr_reg <= (wptr_reg == AW'(DEPTH-1)) ? '0 : wptr_reg + 1'b1;
			end
			if (pop) begin
				rptr_reg <= (rptr_reg == AW'(DEPTH-1)) ? '0 : rptr_reg + 1'b1;
			end
			count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : byte_fifo

// File: rtl/dma_ctrl_regs.sv
// control and status registers of a four-channel dma controller
`timescale 1ns/1ps
`include "dma_ctrl_params.svh"
module dma_ctrl_regs (
	input  wire logic                     ref_clk,
	input  wire logic                     reset,
	input  wire logic                     clk_en,
	input  wire dma_ctrl_pkg::host_req_t  host_req,
	output logic [7:0]                    host_rdata,
	input  wire logic [3:0]               chan_request_in,
	output logic [3:0]                    chan_ack_out,
	output logic                          hold_request_out,
	input  wire logic                     hold_ack_in,
	input  wire logic [3:0]               tc_event,
	input  wire logic                     end_in,
	input  wire logic                     xfer_done,
	input  wire logic                     m2m_byte_valid,
	input  wire logic [7:0]               m2m_byte,
	output logic                          m2m_byte_ready,
	output dma_ctrl_pkg::chan_mode_t      eff_mode_0,
	output dma_ctrl_pkg::chan_mode_t      eff_mode_1,
	output dma_ctrl_pkg::chan_mode_t      eff_mode_2,
	output dma_ctrl_pkg::chan_mode_t      eff_mode_3,
	output logic                          src_hold_active,
	output logic                          m2m_active,
	output logic                          write_follows_read,
	output logic                          compressed_active,
	output logic [1:0]                    service_chan
);
	import dma_ctrl_pkg::*;

	dev_ctrl_t  ctrl_reg;
	chan_mode_t mode_reg [4];
	logic [3:0] mask_reg;
	logic [3:0] soft_req_reg;
	logic [3:0] tc_reg;
	logic [7:0] temp_byte_reg;
	logic [3:0] req_meta_reg;
	logic [3:0] req_sync_reg;
	logic       hack_meta_reg;
	logic       hack_sync_reg;
	logic       end_meta_reg;
	logic       end_sync_reg;
	logic [1:0] last_chan_reg;
	logic       busy_reg;
	logic [1:0] cur_chan_reg;
	logic [7:0] rdata_reg;
	logic [3:0] ack_reg;
	logic       hold_reg;
	logic       soft_reset;
	logic       wr_ctrl;
	logic       rd_status;
	logic [3:0] hw_req;
	logic [3:0] pending;
	logic       grant_valid;
	logic [1:0] grant_chan;
	logic [1:0] fifo_unused;
	logic       fifo_valid;
	logic [7:0] fifo_byte;
	logic [1:0] sel;

	assign sel        = host_req.wdata[1:0];
	assign wr_ctrl    = clk_en && host_req.wr;
	assign rd_status  = clk_en && host_req.rd &&
		host_req.addr == `ADDR_CTRL_STATUS;
	assign soft_reset = wr_ctrl && host_req.addr == `ADDR_TEMP_RESET;
	assign fifo_unused = 2'b00;

	// pins cross into ref_clk through two flops
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			req_meta_reg  <= 4'h0;
			req_sync_reg  <= 4'h0;
			hack_meta_reg <= 1'b0;
			hack_sync_reg <= 1'b0;
			end_meta_reg  <= 1'b0;
			end_sync_reg  <= 1'b0;
		end else if (clk_en) begin
			req_meta_reg  <= chan_request_in;
			req_sync_reg  <= req_meta_reg;
			hack_meta_reg <= hold_ack_in;
			hack_sync_reg <= hack_meta_reg;
			end_meta_reg  <= end_in;
			end_sync_reg  <= end_meta_reg;
		end
	end

	// polarity applied after the synchroniser
	assign hw_req = ctrl_reg.req_level_sel ? ~req_sync_reg
		: req_sync_reg;
	assign pending = (hw_req & ~mask_reg) | soft_req_reg;

	// fixed or rotating choice among pending channels
	always_comb begin
		logic [1:0] start;
		logic [1:0] idx;
		idx         = 2'd0;
		start       = ctrl_reg.rotate_priority ? last_chan_reg + 2'd1
			: 2'd0;
		grant_valid = 1'b0;
		grant_chan  = 2'd0;
		for (int i = 3; i >= 0; i--) begin
			idx = start + 2'(i);
			if (pending[idx]) begin
				grant_valid = 1'b1;
				grant_chan  = idx;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			ctrl_reg <= `CTRL_RESET;
		end else if (soft_reset) begin
			ctrl_reg <= `CTRL_RESET;
		end else if (wr_ctrl && host_req.addr == `ADDR_CTRL_STATUS) begin
			ctrl_reg <= host_req.wdata;
		end
	end

	// mode copies are not cleared by a software reset
	generate
		for (genvar c = 0; c < 4; c++) begin : g_mode
			always_ff @(posedge ref_clk or posedge reset) begin
				if (reset) begin
					mode_reg[c] <= '0;
				end else if (wr_ctrl && host_req.addr == `ADDR_MODE &&
						sel == 2'(c)) begin
					mode_reg[c] <= host_req.wdata[7:2];
				end
			end
		end
	endgenerate

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			mask_reg <= `MASK_RESET;
		end else if (soft_reset) begin
			mask_reg <= `MASK_RESET;
		end else if (wr_ctrl && host_req.addr == `ADDR_MASK_ONE) begin
			mask_reg[sel] <= host_req.wdata[`BIT_SET_FLAG];
		end else if (wr_ctrl && host_req.addr == `ADDR_MASK_ALL) begin
			mask_reg <= host_req.wdata[3:0];
		end else if (wr_ctrl && host_req.addr == `ADDR_CLEAR_MASKS) begin
			mask_reg <= 4'h0;
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			soft_req_reg <= 4'h0;
		end else if (soft_reset) begin
			soft_req_reg <= 4'h0;
		end else if (wr_ctrl && host_req.addr == `ADDR_SOFT_REQ) begin
			soft_req_reg[sel] <= host_req.wdata[`BIT_SET_FLAG];
		end else if (clk_en && busy_reg && xfer_done) begin
			soft_req_reg[cur_chan_reg] <= 1'b0;
		end
	end

	// a new event wins over the read-clear in the same cycle
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			tc_reg <= 4'h0;
		end else if (soft_reset) begin
			tc_reg <= 4'h0;
		end else if (clk_en) begin
			for (int c = 0; c < 4; c++) begin
				if (tc_event[c] ||
						(end_sync_reg && busy_reg && cur_chan_reg == 2'(c))) begin
					tc_reg[c] <= 1'b1;
				end else if (rd_status) begin
					tc_reg[c] <= 1'b0;
				end
			end
		end
	end

	// the fifo absorbs a burst of bytes; only the newest is kept
	byte_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH)) u_fifo (
		.ref_clk   (ref_clk),
		.reset     (reset),
		.clk_en    (clk_en),
		.in_valid  (m2m_byte_valid && m2m_active),
		.in_ready  (m2m_byte_ready),
		.in_data   (m2m_byte),
		.out_valid (fifo_valid),
		.out_ready (!soft_reset),
		.out_data  (fifo_byte)
	);

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			temp_byte_reg <= 8'h00;
		end else if (soft_reset) begin
			temp_byte_reg <= 8'h00;
		end else if (clk_en && fifo_valid) begin
			temp_byte_reg <= fifo_byte;
		end
	end

	// hold request, service channel and rotation memory
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			hold_reg      <= 1'b0;
			busy_reg      <= 1'b0;
			cur_chan_reg  <= 2'd0;
			last_chan_reg <= 2'd3;
		end else if (soft_reset || (clk_en && ctrl_reg.dma_disable)) begin
			hold_reg <= 1'b0;
			busy_reg <= 1'b0;
		end else if (clk_en) begin
			if (!busy_reg) begin
				hold_reg <= grant_valid;
				if (grant_valid && hold_reg && hack_sync_reg) begin
					busy_reg     <= 1'b1;
					cur_chan_reg <= grant_chan;
				end
			end else if (xfer_done || end_sync_reg) begin
				busy_reg      <= 1'b0;
				hold_reg      <= 1'b0;
				last_chan_reg <= cur_chan_reg;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			ack_reg <= 4'hF;
		end else if (clk_en) begin
			for (int c = 0; c < 4; c++) begin
				ack_reg[c] <= (busy_reg && cur_chan_reg == 2'(c)) ~^
					ctrl_reg.ack_level_sel;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			rdata_reg <= 8'h00;
		end else if (clk_en && host_req.rd) begin
			unique case (host_req.addr)
				`ADDR_CTRL_STATUS: rdata_reg <= {hw_req, tc_reg};
				`ADDR_TEMP_RESET:  rdata_reg <= temp_byte_reg;
				default:           rdata_reg <= 8'h00;
			endcase
		end
	end

	// effective per-channel settings seen by the transfer engine
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			eff_mode_0         <= '0;
			eff_mode_1         <= '0;
			eff_mode_2         <= '0;
			eff_mode_3         <= '0;
			m2m_active         <= 1'b0;
			src_hold_active    <= 1'b0;
			write_follows_read <= 1'b0;
			compressed_active  <= 1'b0;
		end else if (clk_en) begin
			eff_mode_0 <= ctrl_reg.mem_to_mem_en ?
				{MODE_BLOCK, mode_reg[0][3:0]} : mode_reg[0];
			eff_mode_1 <= ctrl_reg.mem_to_mem_en ?
				{MODE_BLOCK, mode_reg[1][3:0]} : mode_reg[1];
			eff_mode_2 <= mode_reg[2];
			eff_mode_3 <= mode_reg[3];
			m2m_active <= ctrl_reg.mem_to_mem_en;
			src_hold_active <= ctrl_reg.mem_to_mem_en &&
				ctrl_reg.src_addr_hold;
			write_follows_read <= ctrl_reg.extended_write;
			compressed_active  <= ctrl_reg.compressed_timing;
		end
	end

	assign host_rdata       = rdata_reg;
	assign chan_ack_out     = ack_reg;
	assign hold_request_out = hold_reg;
	assign service_chan     = cur_chan_reg;
endmodule : dma_ctrl_regs

// File: verification/dma_ctrl_regs_sva.sv
// concurrent checks on the ports of the dma control register block
`timescale 1ns/1ps
module dma_ctrl_regs_sva (
	input  wire logic                    ref_clk,
	input  wire logic                    reset,
	input  wire logic                    clk_en,
	input  wire dma_ctrl_pkg::host_req_t host_req,
	input  wire logic [7:0]              host_rdata,
	input  wire logic [3:0]              chan_ack_out,
	input  wire logic                    hold_request_out,
	input  wire logic [3:0]              tc_event
);
	import dma_ctrl_pkg::*;
	logic [7:0] ctrl_reg;
	logic [3:0] idle;
	// the control byte is write-only, so it is shadowed from the host writes
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset)
			ctrl_reg <= 8'h00;
		else if (clk_en && host_req.wr && host_req.addr == 4'h8)
			ctrl_reg <= host_req.wdata;
		else if (clk_en && host_req.wr && host_req.addr == 4'hD)
			ctrl_reg <= 8'h00;
	end
	assign idle = {4{~ctrl_reg[7]}};
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	sequence s_rd8;
		clk_en && host_req.rd && host_req.addr == 4'h8 && tc_event == 4'h0;
	endsequence
	sequence s_swreset;
		clk_en && host_req.wr && host_req.addr == 4'hD && !hold_request_out;
	endsequence
	AST_DISABLE_HOLD: assert property (ctrl_reg[2] && $past(ctrl_reg[2])
		|-> !hold_request_out) else $error("hold raised while disabled");
	AST_ACK_IDLE: assert property ($stable(ctrl_reg) && !hold_request_out
		&& !$past(hold_request_out) && !$past(hold_request_out, 2)
		|-> chan_ack_out == idle) else $error("idle ack level wrong");
	AST_ACK_ONE: assert property ($stable(ctrl_reg)
		|-> $countones(chan_ack_out ^ idle) <= 1) else $error("two acks");
	AST_ACK_HOLD: assert property ($stable(ctrl_reg) && chan_ack_out != idle
		|-> hold_request_out || $past(hold_request_out))
		else $error("ack without hold");
	AST_TC_SET: assert property (clk_en && tc_event != 4'h0 ##1 s_rd8
		|=> (host_rdata[3:0] & $past(tc_event, 2)) == $past(tc_event, 2))
		else $error("terminal count flag missing");
	AST_TC_CLEAR: assert property (s_rd8 ##1 tc_event == 4'h0 ##1 s_rd8
		|=> host_rdata[3:0] == 4'h0) else $error("flags not cleared");
	AST_SWRESET: assert property (s_swreset |=> ##1 chan_ack_out == 4'hF)
		else $error("software reset left ack active");
	AST_RDATA_HOLD: assert property (!host_req.rd && !host_req.wr
		|=> $stable(host_rdata)) else $error("read data changed");
endmodule : dma_ctrl_regs_sva
bind dma_ctrl_regs dma_ctrl_regs_sva i_sva (.ref_clk(ref_clk), .reset(reset),
	.clk_en(clk_en), .host_req(host_req), .host_rdata(host_rdata),
	.chan_ack_out(chan_ack_out), .hold_request_out(hold_request_out),
	.tc_event(tc_event));

// File: verification/hold_host_model.sv
// host side model: grants the hold request and ends each service
`timescale 1ns/1ps
module hold_host_model (
	input  wire logic ref_clk,
	input  wire logic reset,
	input  wire logic slow,
	input  wire logic hold_request_out,
	output logic      hold_ack_in,
	output logic      xfer_done
);
	logic [3:0] cnt_reg;
	// grant two or seven cycles after hold rises; the grant is withdrawn once hold drops
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset || !hold_request_out) begin
			cnt_reg     <= 4'h0;
			hold_ack_in <= 1'b0;
			xfer_done   <= 1'b0;
		end else begin
			cnt_reg     <= cnt_reg + 4'h1;
			hold_ack_in <= hold_ack_in | (cnt_reg == (slow ? 4'h6 : 4'h1));
			xfer_done   <= (cnt_reg == 4'hE);
		end
	end
endmodule : hold_host_model

// File: verification/dma_channel_control_registers_tb_top.sv
// self-checking bench for the dma control register block
`timescale 1ns/1ps
module dma_channel_control_registers_tb_top;
	import dma_ctrl_pkg::*;
	logic       ref_clk = 0, reset = 1, slow = 0, m2m_byte_valid = 0;
	logic       hold_ack_in, xfer_done, hold_request_out, m2m_byte_ready;
	logic       sha, m2a, wfr, cpa;
	logic [7:0] host_rdata, b, m2m_byte = 8'h00, q[$];
	logic [3:0] chan_request_in = 4'h0, tc_event = 4'h0, chan_ack_out;
	logic [1:0] service_chan;
	host_req_t  host_req = '0;
	chan_mode_t em[4], m[4];
	int         err_count = 0, comparisons = 0;
	always #2.5 ref_clk = ~ref_clk;
	dma_ctrl_regs i_dut (.ref_clk(ref_clk), .reset(reset), .clk_en(1'b1),
		.host_req(host_req), .host_rdata(host_rdata),
		.chan_request_in(chan_request_in), .chan_ack_out(chan_ack_out),
		.hold_request_out(hold_request_out), .hold_ack_in(hold_ack_in),
		.tc_event(tc_event), .end_in(1'b0), .xfer_done(xfer_done),
		.m2m_byte_valid(m2m_byte_valid), .m2m_byte(m2m_byte),
		.m2m_byte_ready(m2m_byte_ready), .eff_mode_0(em[0]),
		.eff_mode_1(em[1]), .eff_mode_2(em[2]), .eff_mode_3(em[3]),
		.src_hold_active(sha), .m2m_active(m2a), .write_follows_read(wfr),
		.compressed_active(cpa), .service_chan(service_chan));
	hold_host_model i_host (.ref_clk(ref_clk), .reset(reset), .slow(slow),
		.hold_request_out(hold_request_out), .hold_ack_in(hold_ack_in),
		.xfer_done(xfer_done));
	task chk(input string n, input logic [7:0] e, input logic [7:0] s);
		comparisons++;
		if (s !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(negedge ref_clk) host_req <= '{1'b1, 1'b0, a, d};
		@(negedge ref_clk) host_req <= '0;
	endtask : wr
	task rd(input logic [3:0] a, input logic [7:0] e);
		@(negedge ref_clk);
		q.push_back(e);
		tc_event <= 4'h0;
		host_req <= '{1'b0, 1'b1, a, 8'h00};
		@(negedge ref_clk) host_req <= '0;
	endtask : rd
	task cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : cyc
	task ack_is(input logic [3:0] e, input logic [1:0] c);
		repeat (60) if (chan_ack_out === 4'hF) @(negedge ref_clk);
		chk("chan_ack_out", {4'h0, e}, {4'h0, chan_ack_out});
		chk("service_chan", {6'h0, c}, {6'h0, service_chan});
		chan_request_in = 4'h0;
		repeat (60) if (hold_request_out !== 1'b0) @(negedge ref_clk);
	endtask : ack_is
	task final_report;
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : final_report
	// read data is registered, so it is settled by the following falling edge
	always @(posedge ref_clk) if (host_req.rd) begin
		@(negedge ref_clk);
		chk("host_rdata", q.pop_front(), host_rdata);
	end
	// the tests need about two hundred cycles
	initial begin
		#100000;
		err_count++;
		final_report;
	end
	initial begin
		void'($urandom(25));
		cyc(10);
		reset = 1'b0;
		rd(4'h8, 8'h00);
		rd(4'hD, 8'h00);
		rd(4'h3, 8'h00);
		chk("chan_ack_out", 8'h0F, {4'h0, chan_ack_out});
		$display("test reset finished");
		for (int c = 0; c < 4; c++) begin
			b = $urandom;
			m[c] = b[7:2];
			if (c == 1) m[1].auto_reload = m[0].auto_reload;
			wr(4'hB, {m[c], c[1:0]});
		end
		// effective modes lag the mode copies by one cycle
		cyc(1);
		for (int c = 0; c < 4; c++) chk("eff_mode", m[c], em[c]);
		// extended_write never meets compressed_timing here
		wr(4'h8, 8'h01);
		cyc(1);
		chk("eff_mode", {2'b0, MODE_BLOCK, m[0][3:0]}, em[0]);
		chk("eff_mode", {2'b0, MODE_BLOCK, m[1][3:0]}, em[1]);
		for (int i = 0; i < 3; i++) begin
			@(negedge ref_clk);
			b = $urandom;
			m2m_byte_valid <= 1'b1;
			m2m_byte <= b;
			while (!m2m_byte_ready) @(negedge ref_clk);
		end
		@(negedge ref_clk) m2m_byte_valid <= 1'b0;
		cyc(4);
		rd(4'hD, b);
		wr(4'h8, 8'h03);
		cyc(1);
		chk("src_hold_active", 8'h01, {7'h0, sha});
		chk("m2m_active", 8'h01, {7'h0, m2a});
		wr(4'h8, 8'h22);
		cyc(1);
		chk("src_hold_active", 8'h00, {7'h0, sha});
		chk("m2m_active", 8'h00, {7'h0, m2a});
		chk("write_follows_read", 8'h01, {7'h0, wfr});
		wr(4'h8, 8'h08);
		cyc(1);
		chk("compressed_active", 8'h01, {7'h0, cpa});
		chk("write_follows_read", 8'h00, {7'h0, wfr});
		$display("test modes finished");
		wr(4'h8, 8'h80);
		cyc(2);
		chk("chan_ack_out", 8'h00, {4'h0, chan_ack_out});
		chan_request_in = 4'b1010;
		wr(4'h8, 8'h40);
		cyc(4);
		rd(4'h8, 8'h50);
		chan_request_in = 4'h0;
		wr(4'h8, 8'h00);
		cyc(4);
		b = $urandom;
		tc_event <= b[3:0] | 4'h1;
		rd(4'h8, {4'h0, b[3:0] | 4'h1});
		rd(4'h8, 8'h00);
		$display("test status finished");
		wr(4'h8, 8'h04);
		wr(4'hA, 8'h00);
		chan_request_in = 4'h1;
		slow = 1'b1;
		cyc(20);
		chk("hold_request_out", 8'h00, {7'h0, hold_request_out});
		rd(4'h8, 8'h10);
		wr(4'h8, 8'h00);
		ack_is(4'hE, 2'd0);
		slow = 1'b0;
		wr(4'hF, 8'h00);
		chan_request_in = 4'b0110;
		ack_is(4'hD, 2'd1);
		wr(4'h8, 8'h10);
		chan_request_in = 4'b0110;
		ack_is(4'hB, 2'd2);
		wr(4'h8, 8'h00);
		wr(4'hF, 8'h0F);
		wr(4'h9, 8'h07);
		ack_is(4'h7, 2'd3);
		$display("test service finished");
		chan_request_in = 4'h1;
		wr(4'hD, 8'h5A);
		cyc(10);
		chk("hold_request_out", 8'h00, {7'h0, hold_request_out});
		rd(4'h8, 8'h10);
		rd(4'hD, 8'h00);
		chk("chan_ack_out", 8'h0F, {4'h0, chan_ack_out});
		chk("eff_mode", m[0], em[0]);
		chk("eff_mode", m[2], em[2]);
		$display("test soft reset finished");
		cyc(4);
		final_report;
	end
endmodule : dma_channel_control_registers_tb_top
